// *** hdl/gdio_pin_sync.sv ***
// Three-stage input synchroniser with agreement filter, one per pin
`timescale 1ns/1ps
`include "gdio_defs.svh"

module gdio_pin_sync #(
    parameter int N = 8
) (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RST_B,
    // Raw pin levels and their synchronised image
    input wire logic [N-1:0] PIN_RAW,
    output logic [N-1:0] PIN_SYNC
);

    genvar g;

    generate
        for (g = 0; g < N; g++) begin : g_bit
            logic [`GDIO_SYNC_STAGES-1:0] st_r;
            logic q_r;

            // Shift chain; stage 0 feeds only stage 1
            always_ff @(posedge CLOCK or negedge RST_B) begin
                if (!RST_B) begin
                    st_r <= '0;
                end else begin
                    st_r <= {st_r[`GDIO_SYNC_STAGES-2:0], PIN_RAW[g]};
                end
            end

            // Accept a level once the second and third stages agree
            always_ff @(posedge CLOCK or negedge RST_B) begin
                if (!RST_B) begin
                    q_r <= `GDIO_RST_BIT;
                end else if (st_r[1] == st_r[2]) begin
                    q_r <= st_r[2];
                end
            end

            assign PIN_SYNC[g] = q_r;
        end
    endgenerate

endmodule

// *** hdl/gdio_port.sv ***
// General digital I/O port with Wishbone register access
`timescale 1ns/1ps
`include "gdio_defs.svh"

module gdio_port #(
    parameter int N = 8
) (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RST_B,
    // Wishbone classic slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Pins, split into input, output, output enable and pull-up
    input wire logic [N-1:0] PIN_IN,
    output logic [N-1:0] PIN_OUT,
    output logic [N-1:0] PIN_OE,
    output logic [N-1:0] PIN_PULLUP
);

    logic [N-1:0] direction_register_r;
    logic [N-1:0] output_value_register_r;
    logic [N-1:0] input_sense;
    logic global_pullup_disable_r;
    logic ack_r;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic req;
    logic wr_en;
    logic wr_dir;
    logic wr_out;
    logic wr_sense;
    logic wr_ctrl;
    gdio_pkg::gdio_reg_t reg_sel;

    // Pin levels brought into the clock domain
    gdio_pin_sync #(
        .N(N)
    ) u_sync (
        .CLOCK(CLOCK),
        .RST_B(RST_B),
        .PIN_RAW(PIN_IN),
        .PIN_SYNC(input_sense)
    );

    // Address decode
    always_comb begin
        unique case (WB_ADR_I)
            `GDIO_OFS_SENSE: reg_sel = gdio_pkg::GDIO_REG_SENSE;
            `GDIO_OFS_DIR: reg_sel = gdio_pkg::GDIO_REG_DIR;
            `GDIO_OFS_OUT: reg_sel = gdio_pkg::GDIO_REG_OUT;
            `GDIO_OFS_CTRL: reg_sel = gdio_pkg::GDIO_REG_CTRL;
            default: reg_sel = gdio_pkg::GDIO_REG_NONE;
        endcase
    end

    // Writes take effect on the edge where ack is seen, lane 0 only
    assign req = WB_CYC_I & WB_STB_I;
    assign wr_en = req & WB_WE_I & ack_r & WB_SEL_I[0];
    assign wr_dir = wr_en & (reg_sel == gdio_pkg::GDIO_REG_DIR);
    assign wr_out = wr_en & (reg_sel == gdio_pkg::GDIO_REG_OUT);
    assign wr_sense = wr_en & (reg_sel == gdio_pkg::GDIO_REG_SENSE);
    assign wr_ctrl = wr_en & (reg_sel == gdio_pkg::GDIO_REG_CTRL);

    // Acknowledge one cycle after the request, drop it the cycle after
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    // Read mux; unmapped addresses and unused bits read as zero
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        unique case (reg_sel)
            gdio_pkg::GDIO_REG_SENSE: rdata_nxt[N-1:0] = input_sense;
            gdio_pkg::GDIO_REG_DIR: rdata_nxt[N-1:0] = direction_register_r;
            gdio_pkg::GDIO_REG_OUT:
                rdata_nxt[N-1:0] = output_value_register_r;
            gdio_pkg::GDIO_REG_CTRL:
                rdata_nxt[`GDIO_CTRL_PUD_BIT] = global_pullup_disable_r;
            gdio_pkg::GDIO_REG_NONE: rdata_nxt = 32'h0000_0000;
        endcase
    end

    // Read data captured together with the rising ack
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            rdata_r <= 32'h0000_0000;
        end else if (req & ~ack_r) begin
            rdata_r <= rdata_nxt;
        end
    end

    // Direction register; async reset makes all pins inputs at once
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            direction_register_r <= {N{`GDIO_RST_BIT}};
        end else if (wr_dir) begin
            direction_register_r <= WB_DAT_I[N-1:0];
        end
    end

    // Output-value register: plain write, or toggle through input-sense
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            output_value_register_r <= {N{`GDIO_RST_BIT}};
        end else if (wr_out) begin
            output_value_register_r <= WB_DAT_I[N-1:0];
        end else if (wr_sense) begin
            output_value_register_r <=
                output_value_register_r ^ WB_DAT_I[N-1:0];
        end
    end

    // Global pull-up disable in the control register
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            global_pullup_disable_r <= `GDIO_RST_BIT;
        end else if (wr_ctrl) begin
            global_pullup_disable_r <= WB_DAT_I[`GDIO_CTRL_PUD_BIT];
        end
    end

    // Bus outputs
    assign WB_ACK_O = ack_r;
    assign WB_DAT_O = rdata_r;

    // Pin drivers; software handles safe mode ordering
    assign PIN_OE = direction_register_r;
    assign PIN_OUT = output_value_register_r;
    assign PIN_PULLUP = ~direction_register_r & output_value_register_r
        & {N{~global_pullup_disable_r}};

    // Checks on the port behaviour
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_B);

    a_dir_sets_oe: assert property (
        wr_dir |=> PIN_OE == $past(WB_DAT_I[N-1:0]))
        else $error("Pin direction did not follow direction write");

    a_pullup_on_input: assert property (
        (~global_pullup_disable_r) |->
        ((PIN_PULLUP & ~PIN_OE) == (output_value_register_r & ~PIN_OE)))
        else $error("Pull-up missing on input pin with value one");

    a_pullup_off_cases: assert property (
        (PIN_PULLUP & (PIN_OE | ~output_value_register_r)) == '0)
        else $error("Pull-up active on output or zero-value pin");

    a_reset_tristate: assert property (
        $past(!RST_B) |-> (PIN_OE == '0 && PIN_PULLUP == '0))
        else $error("Pins not tri-stated after reset");

    a_drive_level: assert property (
        wr_out |=> (PIN_OUT == $past(WB_DAT_I[N-1:0]))
        and ((PIN_OUT & PIN_OE) == (output_value_register_r & PIN_OE)))
        else $error("Output level does not match written value");

    a_toggle_value: assert property (
        wr_sense |=> output_value_register_r ==
        ($past(output_value_register_r) ^ $past(WB_DAT_I[N-1:0])))
        else $error("Input-sense write did not toggle output value");

    a_pud_global: assert property (
        global_pullup_disable_r |-> PIN_PULLUP == '0)
        else $error("Pull-up active while globally disabled");

    a_sense_no_store: assert property (
        wr_sense |=> direction_register_r == $past(direction_register_r))
        else $error("Input-sense write disturbed direction register");

    a_sense_readback: assert property (
        (req & ~ack_r & ~WB_WE_I & (reg_sel == gdio_pkg::GDIO_REG_SENSE))
        |=> (WB_ACK_O && WB_DAT_O[N-1:0] == $past(input_sense)))
        else $error("Input-sense read returned wrong level");

    a_ack_one_cycle: assert property (
        (req & ~ack_r) |=> WB_ACK_O ##1 !WB_ACK_O)
        else $error("Bus ack not a single cycle one edge after request");

    a_regs_separate: assert property (
        wr_dir |=> output_value_register_r == $past(output_value_register_r))
        else $error("Direction write disturbed output-value register");

    a_lane_gate: assert property (
        (req & WB_WE_I & ack_r & ~WB_SEL_I[0]) |=>
        (direction_register_r == $past(direction_register_r)
        && output_value_register_r == $past(output_value_register_r)
        && global_pullup_disable_r == $past(global_pullup_disable_r)))
        else $error("Write without lane zero changed a register");

    a_out_hold: assert property (
        !(wr_out | wr_sense) |=> $stable(PIN_OUT))
        else $error("Output level changed without a register write");

    a_unmapped_zero: assert property (
        (req & ~ack_r & ~WB_WE_I & (reg_sel == gdio_pkg::GDIO_REG_NONE))
        |=> WB_DAT_O == '0)
        else $error("Unmapped address read returned nonzero data");

endmodule

// *** inc/gdio_defs.svh ***
// Register offsets, field positions and reset values of the port block
`ifndef GDIO_DEFS_SVH
`define GDIO_DEFS_SVH

// Byte offsets on the register bus
`define GDIO_OFS_SENSE 8'h00
`define GDIO_OFS_DIR 8'h04
`define GDIO_OFS_OUT 8'h08
`define GDIO_OFS_CTRL 8'h0c

// Field position of the global pull-up disable in the control register
`define GDIO_CTRL_PUD_BIT 0

// Reset value of every per-pin bit and of the control bit
`define GDIO_RST_BIT 1'b0

// Synchroniser depth on pin inputs
`define GDIO_SYNC_STAGES 3

`endif

// *** inc/gdio_pkg.sv ***
// Types shared by the port block
package gdio_pkg;

    // Register selected by the current bus address
    typedef enum logic [2:0] {
        GDIO_REG_SENSE = 3'b000,
        GDIO_REG_DIR = 3'b001,
        GDIO_REG_OUT = 3'b010,
        GDIO_REG_CTRL = 3'b011,
        GDIO_REG_NONE = 3'b100
    } gdio_reg_t;

endpackage

// *** verification/gdio_pad_model.sv ***
// Board-side pad model that resolves the level seen on each pin
`timescale 1ns/1ps
module gdio_pad_model #(
    parameter int N = 8
) (
    // Clock
    input wire logic clk,
    // Port side of the pad
    input wire logic [N-1:0] oe,
    input wire logic [N-1:0] drv,
    input wire logic [N-1:0] pu,
    // Board drivers
    input wire logic [N-1:0] ext_en,
    input wire logic [N-1:0] ext_val,
    // Resolved level
    output logic [N-1:0] level
);
    logic [N-1:0] float_r = '0;
    // Undriven lines wander each cycle so no stale level reads back
    always @(posedge clk) begin
        float_r <= ~float_r;
    end
    // Port drive wins, then board, then weak pull-up, else floating
    assign level = (oe & drv) | (~oe & ext_en & ext_val)
        | (~oe & ~ext_en & pu) | (~oe & ~ext_en & ~pu & float_r);
endmodule

// *** verification/gdio_port_test.sv ***
// Self-checking bench for the port block
`timescale 1ns/1ps
module gdio_port_test;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hf;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic [31:0] rd;
    logic ack;
    logic [7:0] pin_in, pin_out, pin_oe, pin_pu;
    logic [7:0] ext_en = 8'h00;
    logic [7:0] ext_val = 8'h00;
    int n_errors = 0;
    int cmp_count = 0;
    gdio_port #(.N(8)) i_gdio_port (.CLOCK(clock), .RST_B(rst_b),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o),
        .WB_ACK_O(ack), .PIN_IN(pin_in), .PIN_OUT(pin_out),
        .PIN_OE(pin_oe), .PIN_PULLUP(pin_pu));
    gdio_pad_model #(.N(8)) i_gdio_pad_model (.clk(clock), .oe(pin_oe),
        .drv(pin_out), .pu(pin_pu), .ext_en(ext_en), .ext_val(ext_val),
        .level(pin_in));
    // Free-running 40 MHz clock
    initial begin
        forever #12.5 clock = ~clock;
    end
    // Counts, verdict and end of run
    task automatic give_verdict();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Compare one value
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One classic bus cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        int k;
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_i <= d;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (ack !== 1'b1 && k < 20);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (k >= 20) begin
            n_errors++;
            $display("[ERR] %0t no ack", $time);
            give_verdict();
        end
    endtask
    // Pin outputs just after the write edge
    task automatic pins(input logic [7:0] e, input logic [7:0] o,
            input logic [7:0] p);
        #1;
        chk({8'h0, pin_oe, pin_out, pin_pu}, {8'h0, e, o, p});
    endtask
    // Reset values and read/write registers
    task automatic t_reset();
        pins(8'h00, 8'h00, 8'h00);
        wb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h0);
        wb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0);
        wb(1'b0, 8'h0c, 32'h0);
        chk(rd, 32'h0);
    endtask
    // Legal walk 00 -> 01 -> 11 -> 10 -> 00, one register per step
    task automatic t_states();
        wb(1'b1, 8'h08, 32'hff);
        pins(8'h00, 8'hff, 8'hff);
        wb(1'b1, 8'h04, 32'hff);
        pins(8'hff, 8'hff, 8'h00);
        wb(1'b1, 8'h08, 32'h00);
        pins(8'hff, 8'h00, 8'h00);
        wb(1'b1, 8'h04, 32'h5a);
        pins(8'h5a, 8'h00, 8'h00);
        wb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h5a);
        wb(1'b1, 8'h04, 32'h00);
        pins(8'h00, 8'h00, 8'h00);
    endtask
    // Global pull-up disable over a pull-up input port
    task automatic t_pud();
        wb(1'b1, 8'h08, 32'hff);
        wb(1'b1, 8'h0c, 32'h1);
        pins(8'h00, 8'hff, 8'h00);
        wb(1'b1, 8'h0c, 32'h0);
        pins(8'h00, 8'hff, 8'hff);
    endtask
    // Ones toggle output value on inputs and outputs alike
    task automatic t_toggle();
        wb(1'b1, 8'h04, 32'h0f);
        wb(1'b1, 8'h00, 32'h3c);
        pins(8'h0f, 8'hc3, 8'hc0);
        wb(1'b1, 8'h00, 32'h00);
        wb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'hc3);
        sel <= 4'he;
        wb(1'b1, 8'h08, 32'hff);
        sel <= 4'hf;
        wb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'hc3);
        wb(1'b1, 8'h10, 32'hff);
        wb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0);
        wb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h0f);
    endtask
    // Sense reads board levels and driven levels
    task automatic t_sense();
        wb(1'b1, 8'h04, 32'h00);
        wb(1'b1, 8'h08, 32'h00);
        ext_en <= 8'hff;
        ext_val <= 8'ha5;
        repeat (8) @(posedge clock);
        wb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'ha5);
        ext_en <= 8'h00;
        wb(1'b1, 8'h08, 32'h3c);
        wb(1'b1, 8'h04, 32'hff);
        repeat (8) @(posedge clock);
        wb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h3c);
    endtask
    // Reset in mid-run tri-states before any further edge
    task automatic t_async_reset();
        wb(1'b1, 8'h0c, 32'h1);
        @(posedge clock);
        rst_b <= 1'b0;
        pins(8'h00, 8'h00, 8'h00);
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
    endtask
    // Main sequence
    initial begin
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        t_reset();
        t_states();
        t_pud();
        t_toggle();
        t_sense();
        t_async_reset();
        t_reset();
        give_verdict();
    end
endmodule
